/* logic/sep_core.sv */
// serial eeprom command port: frame decoder, array, self-timed write
// assumes pins arrive unsynchronised; clk_sys well above sck rate
//
// How it works
// - array holds 16384 bytes, one per address
// - frame is 8-bit op-code, then 16-bit address, then data bytes
// - six commands: read, write, latch set/clear, status read/write
// - first bit sampled on first sck rise after select falls
// - every byte moves msb first both ways
// - select high: input ignored, output released
// - unknown op-code: rest of frame ignored, output released
// - hold falling with sck low pauses the transfer
// - hold rising with sck low resumes the transfer
// - while paused all sck edges are ignored
// - gate bit 0: status write needs only the latch
// - gate bit 1 and protect pin low: status write refused
// - gate bit 1, pin high, latch set: status write taken
// - gate bit 1: protect pin low during shifting cancels the status write
// - a started programming cycle ignores the protect pin
// - page write programs up to 64 bytes of one page
// - programming is self-timed: 5 ms timer plus flush and commit cycles
// - cells erased automatically as part of each write
// - block protection: top quarter, top half or whole array
// - latch cleared automatically after any programming
`include "sep_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module sep_core #(
    parameter int PROG_CYC = `SEP_PROG_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic busy,
    output logic write_en_latch,
    output logic protect_pin_gate,
    output sep_pkg::sep_bp_t block_protect
);
    import sep_pkg::*;
    localparam int PCW = $clog2(PROG_CYC + 1);

    logic [4:0] s1;
    logic [4:0] s2;
    logic c3, k3, h3;
    logic cs_idle, sck_s, si_s, hold_s, wp_s;
    logic held, rise, fall, cs_rise;
    sep_phase_t phase, op_next;
    logic [3:0] bcnt;
    logic [7:0] sr, nxt, out_sr, sw_val, stat_byte;
    logic [15:0] asr, a16;
    logic [7:0] pg;
    logic [5:0] off, ci;
    logic [2:0] ocnt, cmd, op_q;
    logic [13:0] rd_addr, a_off;
    logic rd_stat, so_on, got_byte, wr_armed, wp_low_seen;
    logic decode, op_valid, op_go, push, prot;
    logic wr_go, sw_go, sw_ok, pg_done, is_sw, wen;
    sep_prog_t pgs;
    logic [PCW-1:0] pcnt;
    logic [7:0] mem [1 << `SEP_AW];
    logic [7:0] pbuf [1 << `SEP_PAGE_W];
    logic [63:0] pmask;
    sep_fifo_if #(.W(`SEP_FIFO_W)) wq ();

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge finding
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1 <= `SEP_SYNC_RST;
            s2 <= `SEP_SYNC_RST;
        end
        else
        begin
            s1 <= {cs_n, sck, si, hold_n, wp_n};
            s2 <= s1;
        end
    end

    assign {cs_idle, sck_s, si_s, hold_s, wp_s} = s2;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            {c3, k3, h3} <= 3'h7;
        end
        else
        begin
            {c3, k3, h3} <= {cs_idle, sck_s, hold_s};
        end
    end

    // hold only counts while sck is low, so a glitch mid-bit is harmless
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            held <= 1'b0;
        end
        else if (!sck_s && h3 && !hold_s)
        begin
            held <= 1'b1;
        end
        else if (!sck_s && !h3 && hold_s)
        begin
            held <= 1'b0;
        end
    end

    assign rise = sck_s && !k3 && !held && !cs_idle;
    assign fall = !sck_s && k3 && !held && !cs_idle;
    assign cs_rise = cs_idle && !c3;

    ////////////////////////////////////////////////////////////////////
    // op-code decode
    assign nxt = {sr[6:0], si_s};
    assign a16 = {asr[14:0], si_s};
    assign cmd = nxt[2:0];
    assign decode = rise && (phase == PH_OPC) && (bcnt[2:0] == `SEP_BYTE_LAST);
    assign op_valid = (nxt[7:4] == `SEP_OP_HI) && (cmd != `SEP_OP_BAD0)
                      && (cmd != `SEP_OP_BAD7);
    // during programming only the status read gets through
    assign op_go = op_valid && (!busy || cmd == `SEP_OP_STAT_RD);
    assign stat_byte = busy ? `SEP_BUSY_STAT
                            : {protect_pin_gate, 3'h0, block_protect, wen, 1'b0};

    always_comb
    begin
        op_next = PH_IGN;
        if (op_go)
        begin
            unique case (cmd)
                `SEP_OP_READ, `SEP_OP_WRITE: op_next = PH_ADDR;
                `SEP_OP_STAT_RD: op_next = PH_OUT;
                `SEP_OP_STAT_WR: op_next = PH_SWR;
                default: op_next = PH_IGN;
            endcase
        end
    end

    assign a_off = {pg, off};
    always_comb
    begin
        unique case (block_protect)
            2'h0: prot = 1'b0;
            2'h1: prot = (a_off >= `SEP_BP_QTR);
            2'h2: prot = (a_off >= `SEP_BP_HALF);
            default: prot = 1'b1;
        endcase
    end

    assign push = rise && (phase == PH_WDATA)
                  && (bcnt[2:0] == `SEP_BYTE_LAST) && wr_armed && !prot;
    assign wq.in_valid = push;
    assign wq.in_data = {off, nxt};

    ////////////////////////////////////////////////////////////////////
    // frame engine: a raised select ends the frame outright
    always_ff @(posedge clk_sys)
    begin
        if (rst || cs_idle)
        begin
            phase <= PH_OPC;
            bcnt <= 4'h0;
            sr <= 8'h00;
            asr <= 16'h0000;
            got_byte <= 1'b0;
            so_on <= 1'b0;
            ocnt <= 3'h0;
            wp_low_seen <= 1'b0;
            wr_armed <= 1'b0;
        end
        else
        begin
            if (!wp_s)
            begin
                wp_low_seen <= 1'b1;
            end
            if (rise)
            begin
                sr <= nxt;
                bcnt <= bcnt + 4'h1;
                unique case (phase)
                    PH_OPC:
                    begin
                        if (bcnt[2:0] == `SEP_BYTE_LAST)
                        begin
                            bcnt <= 4'h0;
                            phase <= op_next;
                            wr_armed <= wen;
                            op_q <= cmd;
                            rd_stat <= 1'b1;
                            out_sr <= stat_byte;
                        end
                    end
                    PH_ADDR:
                    begin
                        asr <= a16;
                        if (bcnt == `SEP_ADDR_LAST)
                        begin
                            bcnt <= 4'h0;
                            pg <= a16[13:6];
                            off <= a16[5:0];
                            rd_stat <= 1'b0;
                            out_sr <= mem[a16[13:0]];
                            rd_addr <= a16[13:0] + 14'h1;
                            phase <= (op_q == `SEP_OP_READ) ? PH_OUT
                                                            : PH_WDATA;
                        end
                    end
                    PH_WDATA:
                    begin
                        if (bcnt[2:0] == `SEP_BYTE_LAST)
                        begin
                            bcnt <= 4'h0;
                            off <= off + 6'h1;
                            got_byte <= 1'b1;
                        end
                    end
                    PH_SWR:
                    begin
                        if (bcnt[2:0] == `SEP_BYTE_LAST)
                        begin
                            bcnt <= 4'h0;
                            sw_val <= nxt;
                            phase <= PH_SWDONE;
                        end
                    end
                    PH_SWDONE: phase <= PH_IGN;
                    PH_OUT: bcnt <= 4'h0;
                    PH_IGN: bcnt <= 4'h0;
                    default: phase <= PH_IGN;
                endcase
            end
            if (fall && phase == PH_OUT)
            begin
                so <= out_sr[7];
                so_on <= 1'b1;
                out_sr <= {out_sr[6:0], 1'b0};
                ocnt <= ocnt + 3'h1;
                if (ocnt == `SEP_BYTE_LAST)
                begin
                    out_sr <= rd_stat ? stat_byte : mem[rd_addr];
                    rd_addr <= rd_stat ? rd_addr : rd_addr + 14'h1;
                end
            end
        end
    end

    assign so_oe = so_on && !cs_idle && !held;

    ////////////////////////////////////////////////////////////////////
    // self-timed programming
    // select must rise on a byte boundary, else the write is dropped
    assign wr_go = cs_rise && (phase == PH_WDATA) && (bcnt == 4'h0)
                   && got_byte && wr_armed;
    assign sw_go = cs_rise && (phase == PH_SWDONE);
    assign sw_ok = wen
                   && (!protect_pin_gate || !wp_low_seen);
    assign pg_done = (pgs == PG_COMMIT) && (is_sw || ci == `SEP_PAGE_LAST);
    assign busy = (pgs != PG_IDLE);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pgs <= PG_IDLE;
            pcnt <= '0;
            ci <= 6'h0;
            is_sw <= 1'b0;
        end
        else
        begin
            unique case (pgs)
                PG_IDLE:
                begin
                    if (wr_go || (sw_go && sw_ok))
                    begin
                        pgs <= PG_FLUSH;
                        is_sw <= sw_go;
                    end
                end
                PG_FLUSH:
                begin
                    if (!wq.out_valid)
                    begin
                        pgs <= PG_TIME;
                        pcnt <= '0;
                    end
                end
                PG_TIME:
                begin
                    pcnt <= pcnt + 1'b1;
                    if (pcnt == PCW'(PROG_CYC - 1))
                    begin
                        pgs <= PG_COMMIT;
                        ci <= 6'h0;
                    end
                end
                PG_COMMIT:
                begin
                    ci <= ci + 6'h1;
                    if (pg_done)
                    begin
                        pgs <= PG_IDLE;
                    end
                end
            endcase
        end
    end

    // page buffer fills while the frame runs; the fifo absorbs bursts
    assign wq.out_ready = (pgs != PG_COMMIT);
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pmask <= 64'h0;
        end
        else if (pg_done && !is_sw)
        begin
            pmask <= 64'h0;
        end
        else if (wq.out_valid && wq.out_ready)
        begin
            pbuf[wq.out_data[13:8]] <= wq.out_data[7:0];
            pmask[wq.out_data[13:8]] <= 1'b1;
        end
    end

    // a whole-byte overwrite stands for erase then program
    always_ff @(posedge clk_sys)
    begin
        if (pgs == PG_COMMIT && !is_sw && pmask[ci])
        begin
            mem[{pg, ci}] <= pbuf[ci];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            protect_pin_gate <= `SEP_GATE_RST;
            block_protect <= `SEP_BP_RST;
        end
        else if (pg_done && is_sw)
        begin
            protect_pin_gate <= sw_val[`SEP_ST_GATE];
            block_protect <= sw_val[`SEP_ST_BP_HI:`SEP_ST_BP_LO];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || pg_done)
        begin
            wen <= 1'b0;
        end
        else if (decode && op_go && cmd == `SEP_OP_LATCH_SET)
        begin
            wen <= 1'b1;
        end
        else if (decode && op_go && cmd == `SEP_OP_LATCH_CLR)
        begin
            wen <= 1'b0;
        end
    end

    assign write_en_latch = wen;

    sep_fifo #(.W(`SEP_FIFO_W), .D(`SEP_FIFO_D)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .f(wq.store)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_so_hiz_idle: assert property (cs_idle |-> !so_oe)
        else $error("output driven while deselected");
    chk_bad_op_ign: assert property (decode && !op_valid |=>
        phase == PH_IGN && !so_oe) else $error("bad op-code not ignored");
    chk_hold_freeze: assert property (held && !cs_idle |=>
        $stable(bcnt) && $stable(sr)) else $error("shift moved in hold");
    chk_hold_enter: assert property ($fell(hold_s) && !sck_s
        |=> held) else $error("hold not entered");
    chk_hold_leave: assert property ($rose(hold_s) && !sck_s
        |=> !held) else $error("hold not left");
    chk_so_on_fall: assert property (!cs_idle && $changed(so)
        |-> $past(fall)) else $error("output moved off a falling edge");
    chk_wp_reject: assert property (sw_go && protect_pin_gate
        && wp_low_seen |=> pgs == PG_IDLE) else $error("protected write ran");
    chk_wen_gate: assert property (sw_go && !wen
        |=> pgs == PG_IDLE) else $error("status write without latch");
    chk_prog_len: assert property (pgs == PG_TIME |->
        pcnt < PCW'(PROG_CYC)) else $error("programming overran");
    chk_wen_autoclr: assert property (pg_done |=> !wen)
        else $error("latch kept after programming");
    chk_commit_wp: assert property (pgs == PG_TIME && !wp_s |=>
        pgs inside {PG_TIME, PG_COMMIT}) else $error("programming cut");

    cov_read_out: cover property (decode && cmd == `SEP_OP_READ ##[1:300]
        phase == PH_OUT);
    cov_page_done: cover property (pg_done && !is_sw);
    cov_status_done: cover property (pg_done && is_sw);
    cov_hold_mid: cover property (held && !cs_idle && phase != PH_OPC);
endmodule
`default_nettype wire

/* inc/sep_consts.svh */
// constants of the serial eeprom command port
// assumes a 50 mhz system clock
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH
`define SEP_OP_HI 4'h0
`define SEP_OP_STAT_WR 3'h1
`define SEP_OP_WRITE 3'h2
`define SEP_OP_READ 3'h3
`define SEP_OP_LATCH_CLR 3'h4
`define SEP_OP_STAT_RD 3'h5
`define SEP_OP_LATCH_SET 3'h6
`define SEP_OP_BAD0 3'h0
`define SEP_OP_BAD7 3'h7
`define SEP_AW 14
`define SEP_PAGE_W 6
`define SEP_PAGE_LAST 6'h3f
`define SEP_ADDR_LAST 4'hf
`define SEP_BYTE_LAST 3'h7
`define SEP_FIFO_W 14
`define SEP_FIFO_D 32
`define SEP_PROG_MS 5
`define SEP_CLK_HZ 50000000
`define SEP_PROG_CYC ((`SEP_PROG_MS * `SEP_CLK_HZ) / 1000)
`define SEP_BP_QTR 14'h3000
`define SEP_BP_HALF 14'h2000
`define SEP_ST_GATE 7
`define SEP_ST_BP_HI 3
`define SEP_ST_BP_LO 2
`define SEP_BUSY_STAT 8'hff
`define SEP_GATE_RST 1'b0
`define SEP_BP_RST 2'h0
`define SEP_SYNC_RST 5'h1f
`endif

/* inc/sep_pkg.sv */
// types of the serial eeprom command port
// assumes nothing beyond the constants header
`default_nettype none
package sep_pkg;
    typedef logic [1:0] sep_bp_t;
    typedef enum logic [2:0] {
        PH_OPC = 3'h0,
        PH_ADDR = 3'h1,
        PH_WDATA = 3'h2,
        PH_SWR = 3'h3,
        PH_SWDONE = 3'h4,
        PH_OUT = 3'h5,
        PH_IGN = 3'h6
    } sep_phase_t;
    typedef enum logic [1:0] {
        PG_IDLE = 2'h0,
        PG_FLUSH = 2'h1,
        PG_TIME = 2'h2,
        PG_COMMIT = 2'h3
    } sep_prog_t;
endpackage
`default_nettype wire

/* inc/sep_fifo_if.sv */
// valid/ready carrier between the frame logic and the write fifo
// assumes both ends on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface sep_fifo_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
    modport client (output in_valid, in_data, out_ready,
                    input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* logic/sep_fifo.sv */
// synchronous fifo holding page write bytes
// assumes one clock, synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module sep_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    sep_fifo_if.store f
);
    import sep_pkg::*;
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic empty;

    assign empty = (wp == rp);
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign f.in_ready = !full;
    assign f.out_valid = !empty;
    assign f.out_data = mem[rp[AW-1:0]];

    always_ff @(posedge clk_sys)
    begin
        if (f.in_valid && !full)
        begin
            mem[wp[AW-1:0]] <= f.in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (f.in_valid && !full)
            begin
                wp <= wp + 1'b1;
            end
            if (f.out_ready && !empty)
            begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/sep_spi_master.sv */
// master model: select, serial clock and data in, clock idles low
// assumes clk_sys at 50 mhz; sck half period is 4 clk, 160 ns period
`timescale 1ns/100ps
`default_nettype none
module sep_spi_master (
    input wire logic clk_sys,
    input wire logic so,
    input wire logic so_oe,
    output var logic cs_n,
    output var logic sck,
    output var logic si
);
    logic oe_seen;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // select toggles before every op-code, idle time first
    task automatic start();
        wait_clk(4);
        cs_n <= 1'b0;
        wait_clk(4);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
        begin
            si <= d[i];
            wait_clk(4);
            sck <= 1'b1;
            wait_clk(3);
            // read late in the high phase, so has settled by then
            @(negedge clk_sys);
            // a released line shows the opposite of its last value
            q[i] = so_oe ? so : !so;
            oe_seen = oe_seen | so_oe;
            @(posedge clk_sys);
            sck <= 1'b0;
        end
    endtask
    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            wait_clk(4);
            sck <= 1'b1;
            wait_clk(4);
            sck <= 1'b0;
        end
    endtask
    // select low up to the last bit; si then flips, never stale
    task automatic stop();
        wait_clk(4);
        cs_n <= 1'b1;
        si <= ~si;
        wait_clk(4);
    endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench of the serial eeprom command port
// assumes sep_core, sep_fifo and the master model; lfsr seed fixed
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sep_pkg::*;
    localparam int PROG = 300;
    logic clk_sys, rst, hold_n, wp_n, cs_n, sck, si;
    logic so, so_oe, busy, write_en_latch, protect_pin_gate;
    sep_bp_t block_protect, bp;
    int num_errors = 0;
    int checked = 0;
    logic [15:0] lfsr = 16'h3812;
    logic [7:0] mem [logic [13:0]];
    logic [7:0] q;
    logic [13:0] a0;
    logic [7:0] bad [5] = '{8'h00, 8'h07, 8'h0f, 8'h14, 8'h84};
    sep_core #(.PROG_CYC(PROG)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .busy(busy),
        .write_en_latch(write_en_latch),
        .protect_pin_gate(protect_pin_gate),
        .block_protect(block_protect));
    sep_spi_master i_mst (.clk_sys(clk_sys), .so(so), .so_oe(so_oe),
        .cs_n(cs_n), .sck(sck), .si(si));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    function automatic logic [7:0] stat(logic g, sep_bp_t b, logic l);
        return {g, 3'h0, b, l, 1'b0};
    endfunction
    function automatic logic locked(logic [13:0] a, sep_bp_t b);
        return b == 2'h3 || (b == 2'h2 && a >= 14'h2000)
            || (b == 2'h1 && a >= 14'h3000);
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h0, g}, {7'h0, e});
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic fin();
        i_mst.stop();
        @(negedge clk_sys);
        chk1(so_oe, 1'b0);
    endtask
    task automatic cmd(input logic [7:0] op);
        i_mst.start();
        i_mst.xfer(op, q);
        fin();
    endtask
    // sck settles low before hold moves; idle clocks must be ignored
    task automatic hold_gap();
        i_mst.wait_clk(4);
        hold_n <= 1'b0;
        i_mst.wait_clk(4);
        @(negedge clk_sys);
        chk1(so_oe, 1'b0);
        i_mst.idle_clocks(5);
        i_mst.wait_clk(4);
        hold_n <= 1'b1;
        i_mst.wait_clk(4);
    endtask
    task automatic send_addr(input logic [13:0] a, input bit h);
        logic [7:0] r;
        r = rnd();
        i_mst.xfer({r[1:0], a[13:8]}, q);
        if (h)
            hold_gap();
        i_mst.xfer(a[7:0], q);
    endtask
    task automatic pw(input logic [13:0] a, input int n);
        logic [7:0] d;
        logic [13:0] p;
        cmd(8'h06);
        i_mst.start();
        i_mst.xfer(8'h02, q);
        send_addr(a, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            d = rnd();
            p = {a[13:6], a[5:0] + 6'(i)};
            i_mst.xfer(d, q);
            if (!locked(p, bp))
                mem[p] = d;
        end
        fin();
    endtask
    task automatic wait_idle(input bit l);
        int n;
        n = 0;
        chk1(busy, 1'b1);
        while (busy === 1'b1 && n < PROG + 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk1(busy, 1'b0);
        if (l)
            chk1(write_en_latch, 1'b0);
    endtask
    task automatic rd_chk(input logic [13:0] a, input int n, input bit h);
        logic [13:0] p;
        p = a;
        i_mst.start();
        i_mst.xfer(8'h03, q);
        send_addr(a, h);
        for (int i = 0; i < n; i++)
        begin
            i_mst.xfer(rnd(), q);
            if (mem.exists(p))
                chk8(q, mem[p]);
            p = p + 14'h1;
            if (h && i == 0)
                hold_gap();
        end
        fin();
    endtask
    task automatic st_rd(input logic [7:0] e);
        i_mst.start();
        i_mst.xfer(8'h05, q);
        i_mst.xfer(rnd(), q);
        chk8(q, e);
        fin();
    endtask
    // drop pulls the protect pin low in mid-frame, a misbehaving master
    task automatic st_wr(input logic [7:0] v, input bit drop);
        cmd(8'h06);
        i_mst.start();
        i_mst.xfer(8'h01, q);
        if (drop)
            wp_n <= 1'b0;
        i_mst.xfer(v, q);
        fin();
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        hold_n = 1'b1;
        wp_n = 1'b1;
        bp = 2'h0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk8({busy, write_en_latch, protect_pin_gate, so_oe, 2'h0,
            block_protect}, 8'h00);
        cmd(8'h0e);
        chk1(write_en_latch, 1'b1);
        cmd(8'h04);
        chk1(write_en_latch, 1'b0);
        cmd(8'h06);
        foreach (bad[i])
        begin
            i_mst.oe_seen = 1'b0;
            i_mst.start();
            i_mst.xfer(bad[i], q);
            repeat (3) i_mst.xfer(rnd(), q);
            fin();
            chk1(i_mst.oe_seen, 1'b0);
            chk1(write_en_latch, 1'b1);
        end
        i_mst.start();
        i_mst.xfer(8'h04, q);
        i_mst.xfer(8'h06, q);
        fin();
        chk1(write_en_latch, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            q = rnd();
            a0 = {q[5:0], rnd()};
            // gate bit is 0 here, so a random protect pin must not matter
            wp_n <= q[7];
            pw(a0, 1 + int'(rnd() & 8'h07));
            wait_idle(1'b1);
            rd_chk(a0, 8, k == 0);
        end
        pw(14'h3000, 1);
        wait_idle(1'b1);
        pw(14'h0000, 1);
        wait_idle(1'b1);
        pw(14'h3ffe, 4);
        wait_idle(1'b1);
        rd_chk(14'h3fc0, 2, 1'b0);
        rd_chk(14'h3ffe, 3, 1'b0);
        pw(14'h1234, 2);
        st_rd(8'hff);
        wait_idle(1'b1);
        wp_n <= 1'b0;
        st_wr(8'h8c, 1'b0);
        wait_idle(1'b1);
        bp = 2'h3;
        st_rd(stat(1'b1, bp, 1'b0));
        st_wr(8'h00, 1'b0);
        i_mst.wait_clk(20);
        st_rd(stat(1'b1, bp, 1'b1));
        pw(a0, 1);
        wait_idle(1'b0);
        rd_chk(a0, 1, 1'b0);
        wp_n <= 1'b1;
        st_wr(8'h84, 1'b0);
        wait_idle(1'b1);
        bp = 2'h1;
        st_rd(stat(1'b1, bp, 1'b0));
        chk8({protect_pin_gate, 5'h0, block_protect},
            {1'b1, 5'h0, bp});
        st_wr(8'h00, 1'b1);
        i_mst.wait_clk(20);
        wp_n <= 1'b1;
        st_rd(stat(1'b1, bp, 1'b1));
        pw(14'h2fff, 1);
        wait_idle(1'b1);
        pw(14'h3000, 1);
        wait_idle(1'b0);
        rd_chk(14'h2fff, 2, 1'b0);
        st_wr(8'h00, 1'b0);
        i_mst.wait_clk(8);
        wp_n <= 1'b0;
        wait_idle(1'b1);
        wp_n <= 1'b1;
        bp = 2'h0;
        st_rd(stat(1'b0, bp, 1'b0));
        // status write with the latch clear must not start programming
        i_mst.start();
        i_mst.xfer(8'h01, q);
        i_mst.xfer(8'h8c, q);
        fin();
        chk1(busy, 1'b0);
        st_rd(stat(1'b0, bp, 1'b0));
        // 70 bytes wrap inside the page, so the last 6 land on the first 6 offsets
        pw(14'h0540, 70);
        wait_idle(1'b1);
        i_mst.oe_seen = 1'b0;
        rd_chk(14'h0540, 64, 1'b0);
        chk1(i_mst.oe_seen, 1'b1);
        stop_test();
    end
    // whole run needs about 30k clk; cut a hang well past that
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
